// [jtag_tap_state_machine_tb_top.sv]
// Self-checking bench joining tester end and device end over the link
`timescale 1ns/100ps
`default_nettype none
module jtag_tap_state_machine_tb_top;
  localparam logic [97:0] PAT = 98'h2_1234_5678_9ABC_DEF0_F0E1_D2C3;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid = 1'b0;
  logic req_tms = 1'b1;
  logic req_tdi = 1'b0;
  logic [97:0] pin_in = 98'h0;
  logic req_ready;
  logic rsp_valid;
  logic rsp_tdo;
  logic [97:0] bsc_out;
  logic [2:0] cur_instr;
  jtap_pkg::jtap_state_t dev_state;
  jtap_pkg::jtap_state_t host_state;
  logic [97:0] dout;
  logic [97:0] keep;
  int err_count = 0;
  int comparisons = 0;

  // 25 MHz system clock
  always #20 sys_clk = ~sys_clk;

  jtap_link_if jtap_link_if_i ();
  jtap_host jtap_host_i (.sys_clk(sys_clk), .rst_b(rst_b), .link(jtap_link_if_i), .req_valid(req_valid),
    .req_ready(req_ready), .req_tms(req_tms), .req_tdi(req_tdi), .rsp_valid(rsp_valid), .rsp_tdo(rsp_tdo),
    .tap_state(host_state));
  jtap_dev jtap_dev_i (.sys_clk(sys_clk), .rst_b(rst_b), .link(jtap_link_if_i), .pin_in(pin_in),
    .bsc_out(bsc_out), .tap_state(dev_state), .cur_instr(cur_instr));
  jtap_link_props jtap_link_props_i (.sys_clk(sys_clk), .rst_b(rst_b), .tck(jtap_link_if_i.tck),
    .tms(jtap_link_if_i.tms), .tdi(jtap_link_if_i.tdi), .tdo(jtap_link_if_i.tdo),
    .tdo_oe(jtap_link_if_i.tdo_oe), .tdo_line(jtap_link_if_i.tdo_line));

  task automatic end_sim;
    $display("Counts: %0d compares, %0d mismatches", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [97:0] got, input logic [97:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One test clock period; waits are bounded so a hang ends the run
  task automatic step(input logic tms, input logic tdi);
    int n;
    for (n = 0; n < 40 && req_ready !== 1'b1; n++)
      @(negedge sys_clk);
    if (req_ready !== 1'b1)
    begin
      err_count++;
      $display("[FAIL] %0t host never ready", $time);
      end_sim();
    end
    req_valid = 1'b1;
    req_tms = tms;
    req_tdi = tdi;
    @(negedge sys_clk);
    req_valid = 1'b0;
    for (n = 0; n < 40 && rsp_valid !== 1'b1; n++)
      @(negedge sys_clk);
    if (rsp_valid !== 1'b1)
    begin
      err_count++;
      $display("[FAIL] %0t no response", $time);
      end_sim();
    end
  endtask : step

  task automatic walk(input logic [15:0] b, input int n);
    for (int i = 0; i < n; i++)
      step(b[i], 1'b0);
  endtask : walk

  // Instruction scan from idle with a pause midway, back to idle
  task automatic ir(input logic [2:0] code);
    logic [2:0] o;
    walk(16'h0003, 4);
    chk(dev_state, jtap_pkg::ST_SH_IR);
    chk(host_state, jtap_pkg::ST_SH_IR);
    step(1'b0, code[0]);
    o[0] = rsp_tdo;
    step(1'b1, code[1]);
    o[1] = rsp_tdo;
    walk(16'h0000, 2);
    chk(dev_state, jtap_pkg::ST_PA_IR);
    walk(16'h0001, 2);
    chk(dev_state, jtap_pkg::ST_SH_IR);
    step(1'b1, code[2]);
    o[2] = rsp_tdo;
    walk(16'h0001, 2);
    chk(cur_instr, code);
    chk(o, 3'h4);
  endtask : ir

  // Data scan from idle, pausing after the first bit, back to idle
  task automatic dr(input int n, input logic [97:0] din);
    keep = bsc_out;
    walk(16'h0001, 3);
    step(1'b1, din[0]);
    dout[0] = rsp_tdo;
    walk(16'h0000, 2);
    chk(dev_state, jtap_pkg::ST_PA_DR);
    walk(16'h0001, 2);
    chk(dev_state, jtap_pkg::ST_SH_DR);
    chk(bsc_out, keep);
    for (int i = 1; i < n; i++)
    begin
      step(i == n - 1, din[i]);
      dout[i] = rsp_tdo;
    end
    walk(16'h0001, 2);
  endtask : dr

  task automatic t_reset;
    chk(dev_state, jtap_pkg::ST_TLR);
    chk(cur_instr, jtap_pkg::INSTR_IDCODE);
    chk(bsc_out, 98'h0);
    walk(16'h0000, 3);
    chk(dev_state, jtap_pkg::ST_RTI);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_sample;
    ir(jtap_pkg::INSTR_SAMPLE);
    pin_in = PAT;
    chk(bsc_out, 98'h0);
    dr(98, ~PAT);
    chk(dout, PAT);
    chk(bsc_out, ~PAT);
    $display("t_sample done");
  endtask : t_sample

  // Capture straight to update, for data and for instruction
  task automatic t_skip;
    ir(jtap_pkg::INSTR_EXTEST);
    pin_in = {PAT[48:0], PAT[97:49]};
    walk(16'h000D, 5);
    chk(bsc_out, {PAT[48:0], PAT[97:49]});
    walk(16'h001B, 6);
    chk(cur_instr, jtap_pkg::IR_CAPTURE);
    $display("t_skip done");
  endtask : t_skip

  task automatic t_bypass;
    ir(jtap_pkg::INSTR_BYPASS);
    dr(4, 98'hD);
    chk(dout[3:1], 3'h5);
    dr(4, 98'h2);
    chk(dout[0], 1'b1);
    chk(bsc_out, keep);
    $display("t_bypass done");
  endtask : t_bypass

  // Reset paths, then the identification value shifted out
  task automatic t_tlr;
    walk(16'h000F, 4);
    chk(dev_state, jtap_pkg::ST_TLR);
    chk(cur_instr, jtap_pkg::INSTR_IDCODE);
    walk(16'h03E2, 10);
    chk(dev_state, jtap_pkg::ST_TLR);
    chk(host_state, jtap_pkg::ST_TLR);
    walk(16'h0000, 1);
    dr(32, 98'h0);
    chk(dout[31:0], jtap_pkg::ID_CODE_VALUE);
    $display("t_tlr done");
  endtask : t_tlr

  // Main sequence
  initial
  begin
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge sys_clk);
    t_reset();
    t_sample();
    t_skip();
    t_bypass();
    t_tlr();
    end_sim();
  end
endmodule : jtag_tap_state_machine_tb_top
`default_nettype wire

// [jtap_dev.sv]
// Device end: test access port controller with instruction, bypass, id and boundary chains
// What this block does
// - Capture-DR loads pins under extest or sample
// - Registers without parallel input hold on capture
// - Capture-DR goes to Exit1-DR or Shift-DR
// - Shift-DR moves selected register one stage
// - Shift-DR stays on low, exits on high
// - Exit1-DR to Update-DR or Pause-DR, no change
// - Pause-DR holds; high moves to Exit2-DR
// - Exit2-DR to Update-DR or back to Shift-DR
// - Update-DR latches chain output on falling edge
// - Chain output changes only in Update-DR
// - Select-IR to Capture-IR or Test-Logic-Reset
// - Capture-IR loads fixed pattern 100
// - Capture-IR goes to Exit1-IR or Shift-IR
// - Shift-IR shifts instruction; high exits
// - Exit1-IR to Update-IR or Pause-IR
// - Pause-IR holds; high moves to Exit2-IR
// - Exit2-IR to Update-IR or back to Shift-IR
// - Update-IR latches instruction on falling edge
// - Five high TMS edges or reset reach Test-Logic-Reset
// - Run-Test/Idle holds on low, high to Select-DR
// - Select-DR to Capture-DR or Select-IR
`timescale 1ns/100ps
`default_nettype none
module jtap_dev (
  input wire logic sys_clk,
  input wire logic rst_b,
  jtap_link_if.dev link,
  input wire logic [jtap_pkg::BSC_LEN-1:0] pin_in,
  output logic [jtap_pkg::BSC_LEN-1:0] bsc_out,
  output jtap_pkg::jtap_state_t tap_state,
  output logic [jtap_pkg::IR_W-1:0] cur_instr
);

  // Synchroniser stages for the link pins and the parallel pins
  logic tck_s1_ff;
  logic tck_s2_ff;
  logic tck_s3_ff;
  logic tms_s1_ff;
  logic tms_s2_ff;
  logic tdi_s1_ff;
  logic tdi_s2_ff;
  logic [jtap_pkg::BSC_LEN-1:0] pin_s1_ff;
  logic [jtap_pkg::BSC_LEN-1:0] pin_s2_ff;

  // Edge strobes of the test clock
  logic tck_rise;
  logic tck_fall;

  // Controller and scan registers
  jtap_pkg::jtap_state_t state_ff;
  logic [jtap_pkg::IR_W-1:0] ir_shift_ff;
  logic [jtap_pkg::IR_W-1:0] ir_ff;
  logic bypass_ff;
  logic [jtap_pkg::IDR_W-1:0] idr_ff;
  logic [jtap_pkg::BSC_LEN-1:0] bsc_shift_ff;
  logic [jtap_pkg::BSC_LEN-1:0] bsc_out_ff;
  logic tdo_ff;
  logic tdo_oe_ff;

  // Selection decoded from the current instruction
  logic sel_bsc;
  logic sel_idr;
  logic tdo_src;

  // Outputs
  assign link.tdo = tdo_ff;
  assign link.tdo_oe = tdo_oe_ff;
  assign bsc_out = bsc_out_ff;
  assign tap_state = state_ff;
  assign cur_instr = ir_ff;

  // Two flops per pin before any logic; third tck flop only for edge finding
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tck_s1_ff <= 1'b0;
      tck_s2_ff <= 1'b0;
      tck_s3_ff <= 1'b0;
      tms_s1_ff <= 1'b1;
      tms_s2_ff <= 1'b1;
      tdi_s1_ff <= 1'b1;
      tdi_s2_ff <= 1'b1;
    end
    else
    begin
      tck_s1_ff <= link.tck;
      tck_s2_ff <= tck_s1_ff;
      tck_s3_ff <= tck_s2_ff;
      tms_s1_ff <= link.tms;
      tms_s2_ff <= tms_s1_ff;
      tdi_s1_ff <= link.tdi;
      tdi_s2_ff <= tdi_s1_ff;
    end
  end

  // Pins are asynchronous; two flops keep a moving pin out of the capture
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end
    else
    begin
      pin_s1_ff <= pin_in;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // TMS and TDI pass the same depth as TCK, so they line up with the edge
  assign tck_rise = tck_s2_ff & ~tck_s3_ff;
  assign tck_fall = ~tck_s2_ff & tck_s3_ff;

  // Unknown codes fall to the bypass bit so the chain never breaks
  assign sel_bsc = (ir_ff == jtap_pkg::INSTR_EXTEST) || (ir_ff == jtap_pkg::INSTR_SAMPLE);
  assign sel_idr = (ir_ff == jtap_pkg::INSTR_IDCODE);

  // Controller steps only on the rising edge of the test clock
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_ff <= jtap_pkg::ST_TLR;
    else if (tck_rise)
      state_ff <= jtap_pkg::jtap_next(state_ff, tms_s2_ff);
  end

  // Instruction shift path: capture fixed pattern, shift LSB first, else hold
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      ir_shift_ff <= jtap_pkg::IR_CAPTURE;
    else if (tck_rise)
    begin
      if (state_ff == jtap_pkg::ST_CAP_IR)
        ir_shift_ff <= jtap_pkg::IR_CAPTURE;
      else if (state_ff == jtap_pkg::ST_SH_IR)
        ir_shift_ff <= {tdi_s2_ff, ir_shift_ff[jtap_pkg::IR_W-1:1]};
    end
  end

  // Current instruction: forced to the id code in reset, latched on the falling edge
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      ir_ff <= jtap_pkg::INSTR_IDCODE;
    else if (state_ff == jtap_pkg::ST_TLR)
      ir_ff <= jtap_pkg::INSTR_IDCODE;
    else if (tck_fall && state_ff == jtap_pkg::ST_UPD_IR)
      ir_ff <= ir_shift_ff;
  end

  // Bypass bit has no parallel input, so capture leaves it alone
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      bypass_ff <= 1'b0;
    else if (tck_rise && state_ff == jtap_pkg::ST_SH_DR && !sel_bsc && !sel_idr)
      bypass_ff <= tdi_s2_ff;
  end

  // Identification register reloads its fixed value on capture
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      idr_ff <= jtap_pkg::ID_CODE_VALUE;
    else if (tck_rise && sel_idr)
    begin
      if (state_ff == jtap_pkg::ST_CAP_DR)
        idr_ff <= jtap_pkg::ID_CODE_VALUE;
      else if (state_ff == jtap_pkg::ST_SH_DR)
        idr_ff <= {tdi_s2_ff, idr_ff[jtap_pkg::IDR_W-1:1]};
    end
  end

  // Boundary chain shift path: pins captured, then shifted toward TDO
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      bsc_shift_ff <= '0;
    else if (tck_rise && sel_bsc)
    begin
      if (state_ff == jtap_pkg::ST_CAP_DR)
        bsc_shift_ff <= pin_s2_ff;
      else if (state_ff == jtap_pkg::ST_SH_DR)
        bsc_shift_ff <= {tdi_s2_ff, bsc_shift_ff[jtap_pkg::BSC_LEN-1:1]};
    end
  end

  // Latched chain output; pins see no ripple while new data shifts in
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      bsc_out_ff <= '0;
    else if (tck_fall && sel_bsc && state_ff == jtap_pkg::ST_UPD_DR)
      bsc_out_ff <= bsc_shift_ff;
  end

  // Serial output source by state and instruction
  always_comb
  begin
    if (state_ff == jtap_pkg::ST_SH_IR)
      tdo_src = ir_shift_ff[0];
    else if (sel_bsc)
      tdo_src = bsc_shift_ff[0];
    else if (sel_idr)
      tdo_src = idr_ff[0];
    else
      tdo_src = bypass_ff;
  end

  // TDO moves on the falling edge so the tester can take it late in the next high phase
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_ff <= tdo_src;
      tdo_oe_ff <= (state_ff == jtap_pkg::ST_SH_DR) || (state_ff == jtap_pkg::ST_SH_IR);
    end
  end

endmodule : jtap_dev
`default_nettype wire

// [jtap_host.sv]
// Tester end: makes the test clock and runs one clock cycle per request
`timescale 1ns/100ps
`default_nettype none
module jtap_host (
  input wire logic sys_clk,
  input wire logic rst_b,
  jtap_link_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_tms,
  input wire logic req_tdi,
  output logic rsp_valid,
  output logic rsp_tdo,
  output jtap_pkg::jtap_state_t tap_state
);

  typedef enum logic [2:0] {
    PH_IDLE = 3'h1,
    PH_LOW  = 3'h2,
    PH_HIGH = 3'h4
  } jtap_phase_t;

  jtap_phase_t phase_ff;
  logic [7:0] cnt_ff;
  logic tck_ff;
  logic tms_ff;
  logic tdi_ff;
  logic tdo_s1_ff;
  logic tdo_s2_ff;
  logic rsp_valid_ff;
  logic rsp_tdo_ff;
  jtap_pkg::jtap_state_t state_ff;
  logic cnt_done;
  localparam logic [7:0] TCK_ONE = 8'h01;

  // Half period ends when the down counter reaches one
  assign cnt_done = (cnt_ff == TCK_ONE);

  // Output wiring
  assign link.tck = tck_ff;
  assign link.tms = tms_ff;
  assign link.tdi = tdi_ff;
  assign req_ready = (phase_ff == PH_IDLE);
  assign rsp_valid = rsp_valid_ff;
  assign rsp_tdo = rsp_tdo_ff;
  assign tap_state = state_ff;

  // Serial return line comes from the device domain
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tdo_s1_ff <= 1'b1;
      tdo_s2_ff <= 1'b1;
    end
    else
    begin
      tdo_s1_ff <= link.tdo_line;
      tdo_s2_ff <= tdo_s1_ff;
    end
  end

  // Clock divider phases; TMS and TDI change only while the clock is low
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      phase_ff <= PH_IDLE;
      cnt_ff <= 8'h00;
      tck_ff <= 1'b0;
      tms_ff <= 1'b1;
      tdi_ff <= 1'b1;
    end
    else
    begin
      unique case (phase_ff)
        PH_IDLE:
        begin
          if (req_valid)
          begin
            tms_ff <= req_tms;
            tdi_ff <= req_tdi;
            cnt_ff <= jtap_pkg::TCK_HALF_CNT;
            phase_ff <= PH_LOW;
          end
        end
        PH_LOW:
        begin
          if (cnt_done)
          begin
            tck_ff <= 1'b1;
            cnt_ff <= jtap_pkg::TCK_HALF_CNT;
            phase_ff <= PH_HIGH;
          end
          else
          begin
            cnt_ff <= cnt_ff - TCK_ONE;
          end
        end
        PH_HIGH:
        begin
          if (cnt_done)
          begin
            tck_ff <= 1'b0;
            phase_ff <= PH_IDLE;
          end
          else
          begin
            cnt_ff <= cnt_ff - TCK_ONE;
          end
        end
        default:
        begin
          phase_ff <= PH_IDLE;
          tck_ff <= 1'b0;
        end
      endcase
    end
  end

  // Mirror of the device controller, stepped at each rising edge
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      state_ff <= jtap_pkg::ST_TLR;
    else if (phase_ff == PH_LOW && cnt_done)
      state_ff <= jtap_pkg::jtap_next(state_ff, tms_ff);
  end

  // TDO taken late in the high phase so the device's change has settled
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rsp_valid_ff <= 1'b0;
      rsp_tdo_ff <= 1'b0;
    end
    else
    begin
      rsp_valid_ff <= (phase_ff == PH_HIGH) && cnt_done;
      if (phase_ff == PH_HIGH && cnt_done)
        rsp_tdo_ff <= tdo_s2_ff;
    end
  end

endmodule : jtap_host
`default_nettype wire

// [jtap_link_if.sv]
// Four-wire test port link between tester end and device end
`timescale 1ns/100ps
`default_nettype none
interface jtap_link_if;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo;
  logic tdo_oe;
  logic tdo_line;

  // Undriven serial output reads as pulled high
  assign tdo_line = tdo_oe ? tdo : 1'b1;

  modport dev (
    input tck,
    input tms,
    input tdi,
    output tdo,
    output tdo_oe
  );

  modport host (
    output tck,
    output tms,
    output tdi,
    input tdo_line
  );
endinterface : jtap_link_if
`default_nettype wire

// [jtap_link_props.sv]
// Wire-level assertions on the test port link joining both ends
`timescale 1ns/100ps
`default_nettype none
module jtap_link_props (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe,
  input wire logic tdo_line
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  logic rise_tms_ff;
  logic [2:0] hi_cnt_ff;

  // Mode level and run of high mode levels seen at test clock rises
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      rise_tms_ff <= 1'b1;
    else if ($rose(tck))
      rise_tms_ff <= tms;

  // Saturates at five, since reset already parks the controller
  always_ff @(posedge sys_clk or negedge rst_b)
    if (!rst_b)
      hi_cnt_ff <= 3'h5;
    else if ($rose(tck))
      hi_cnt_ff <= !tms ? 3'h0 : ((hi_cnt_ff == 3'h5) ? 3'h5 : hi_cnt_ff + 3'h1);

  sequence s_high_phase;
    tck [*4] ##1 !tck;
  endsequence

  sequence s_low_phase;
    !tck [*5];
  endsequence

  property p_tck_high;
    $rose(tck) |-> s_high_phase;
  endproperty
  property p_tck_low;
    $fell(tck) |-> s_low_phase;
  endproperty
  property p_tms_hold;
    tck |-> $stable(tms) && $stable(tdi);
  endproperty
  property p_tdo_quiet;
    tck |-> $stable(tdo) && $stable(tdo_oe);
  endproperty
  property p_oe_enter;
    $rose(tdo_oe) |-> !rise_tms_ff;
  endproperty
  property p_oe_leave;
    $fell(tdo_oe) |-> rise_tms_ff;
  endproperty
  property p_oe_stay;
    tdo_oe && $rose(tck) && !tms |-> tdo_oe [*8];
  endproperty
  property p_tlr_quiet;
    (hi_cnt_ff == 3'h5) && $fell(tck) |-> ##6 !tdo_oe && tdo_line;
  endproperty

  a_tck_high: assert property (p_tck_high) else $error("test clock high phase wrong length");
  a_tck_low: assert property (p_tck_low) else $error("test clock low phase too short");
  a_tms_hold: assert property (p_tms_hold) else $error("mode or data moved while clock high");
  a_tdo_quiet: assert property (p_tdo_quiet) else $error("serial out moved while clock high");
  a_oe_enter: assert property (p_oe_enter) else $error("drive began without low mode");
  a_oe_leave: assert property (p_oe_leave) else $error("drive ended without high mode");
  a_oe_stay: assert property (p_oe_stay) else $error("shift left with low mode");
  a_tlr_quiet: assert property (p_tlr_quiet) else $error("line driven after five high modes");
endmodule : jtap_link_props
`default_nettype wire

// [jtap_pkg.sv]
// Shared constants, state encoding and next-state function of the test access port
package jtap_pkg;

  // Controller states, one-hot
  typedef enum logic [15:0] {
    ST_TLR    = 16'h0001,
    ST_RTI    = 16'h0002,
    ST_SEL_DR = 16'h0004,
    ST_CAP_DR = 16'h0008,
    ST_SH_DR  = 16'h0010,
    ST_EX1_DR = 16'h0020,
    ST_PA_DR  = 16'h0040,
    ST_EX2_DR = 16'h0080,
    ST_UPD_DR = 16'h0100,
    ST_SEL_IR = 16'h0200,
    ST_CAP_IR = 16'h0400,
    ST_SH_IR  = 16'h0800,
    ST_EX1_IR = 16'h1000,
    ST_PA_IR  = 16'h2000,
    ST_EX2_IR = 16'h4000,
    ST_UPD_IR = 16'h8000
  } jtap_state_t;

  // Register sizes
  localparam int IR_W = 3;
  localparam int BSC_LEN = 98;
  localparam int IDR_W = 32;

  // Instruction codes and fixed capture pattern
  localparam logic [IR_W-1:0] INSTR_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] INSTR_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] INSTR_IDCODE = 3'h6;
  localparam logic [IR_W-1:0] INSTR_BYPASS = 3'h7;
  localparam logic [IR_W-1:0] IR_CAPTURE = 3'h4;

  // Identification value; arbitrary, bit 0 must stay set
  localparam logic [IDR_W-1:0] ID_CODE_VALUE = 32'h0A5A_5001;

  // Link timing: system clock period and test clock period
  localparam int SYS_CLK_NS = 40;
  localparam int TCK_PERIOD_NS = 320;
  localparam int TCK_HALF_CYC = (TCK_PERIOD_NS / SYS_CLK_NS) / 2;
  localparam logic [7:0] TCK_HALF_CNT = 8'(TCK_HALF_CYC);

  // Next state on a rising edge of the test clock
  function automatic jtap_state_t jtap_next(input jtap_state_t cur, input logic tms);
    jtap_state_t nxt;
    nxt = ST_TLR;
    unique case (cur)
      ST_TLR:    nxt = tms ? ST_TLR : ST_RTI;
      ST_RTI:    nxt = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: nxt = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: nxt = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  nxt = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: nxt = tms ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR:  nxt = tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: nxt = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: nxt = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: nxt = tms ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: nxt = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  nxt = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: nxt = tms ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR:  nxt = tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: nxt = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: nxt = tms ? ST_SEL_DR : ST_RTI;
      // Illegal code falls back to reset state
      default:   nxt = ST_TLR;
    endcase
    return nxt;
  endfunction : jtap_next

endpackage : jtap_pkg
